// ==== logic/ics_pkg.sv ====
// Package for the I2C slave clock stretching block
package ics_pkg;
    // Register offsets on the plain register port
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_DATA = 3'h1;
    localparam logic [2:0] ADDR_SLAVE = 3'h2;
    localparam logic [2:0] ADDR_STATUS = 3'h3;
    // Control register fields
    localparam int CTRL_STRETCH = 0;
    localparam int CTRL_RELEASE = 1;
    localparam int CTRL_TEN_BIT = 2;
    // Status register fields
    localparam int ST_BUFFER_FULL = 0;
    localparam int ST_ADDR_UPDATE = 1;
    localparam int ST_TRANSMIT = 2;
    localparam int ST_SCL_HELD = 3;
    localparam int ST_RELEASE = 4;
    // Reset values
    localparam logic [7:0] SLAVE_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Bit count of a byte plus acknowledge
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] NINTH_CLOCK = 4'h9;
    // Upper byte marker of a 10-bit address
    localparam logic [4:0] TEN_BIT_MARK = 5'h1E;

    typedef enum logic [2:0] {
        ICS_IDLE = 3'b000,
        ICS_ADDR1 = 3'b001,
        ICS_ADDR2 = 3'b011,
        ICS_DATA = 3'b010
    } ics_phase_t;

    // Link side state, clocked by SCL rising edges
    typedef struct packed {
        logic [7:0] shift;
        logic [3:0] bit_count;
        logic [1:0] sda_sync;
        logic start_seen;
    } ics_link_t;

    // Events from link to core: toggles and the received byte value that cross clocks
    typedef struct packed {
        logic byte_tgl;
        logic start_tgl;
        logic [7:0] byte_val;
    } ics_event_t;

    // Core side state
    typedef struct packed {
        ics_phase_t phase;
        logic stretch_enable;
        logic ten_bit;
        logic clock_release_bit;
        logic buffer_full_flag;
        logic address_update_flag;
        logic addr_hold;
        logic transmit;
        logic matched_hi;
        logic [7:0] shift_data_buffer;
        logic [7:0] slave_address_register;
        logic [7:0] rd_data;
        logic [1:0] byte_sync;
        logic byte_seen;
        logic [1:0] start_sync;
        logic start_seen;
        logic [1:0] scl_sync;
        logic scl_last;
        logic ninth_armed;
    } ics_core_t;
endpackage : ics_pkg

// ==== logic/ics_stretch.sv ====
// I2C slave clock stretching control with register port
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ics_stretch (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic scl_clk_in,
    input wire logic sda_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic scl_oe_out,
    output logic scl_out
);
    logic [1:0] rst_sync;
    logic rst_n;
    ics_pkg::ics_link_t link, next_link;
    ics_pkg::ics_event_t ev, next_ev;
    ics_pkg::ics_core_t st, next_st;
    logic byte_evt;
    logic start_evt;
    logic ninth_fall;
    logic start_req;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Start is SDA falling while SCL is high; the toggle is stable long
    // before the next SCL rise, so the link domain can compare it safely.
    always_ff @(negedge sda_in or negedge rst_n) begin
        if (!rst_n) begin
            start_req <= 1'b0;
        end else if (scl_clk_in) begin
            start_req <= ~start_req;
        end
    end

    // Link domain: shifts on SCL rising edges; start is the start_req toggle
    // from the SDA falling-edge flop, compared at each rise; sda_sync is unused.
    always_comb begin
        next_link = link;
        next_ev = ev;
        next_link.sda_sync = {link.sda_sync[0], sda_in};
        if (link.bit_count == ics_pkg::BITS_PER_BYTE) begin
            next_link.bit_count = 4'h0;
            next_ev.byte_val = link.shift;
            next_ev.byte_tgl = ~ev.byte_tgl;
        end else begin
            next_link.shift = {link.shift[6:0], sda_in};
            next_link.bit_count = link.bit_count + 4'h1;
        end
        // A fresh start restarts the bit count with this rise as bit one
        if (start_req != link.start_seen) begin
            next_link.start_seen = start_req;
            next_link.bit_count = 4'h1;
            next_link.shift = {7'h00, sda_in};
            next_ev.start_tgl = ~ev.start_tgl;
        end
    end

    always_ff @(posedge scl_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            link <= '0;
            ev <= '0;
        end else begin
            link <= next_link;
            ev <= next_ev;
        end
    end

    // Byte value is stable long before its toggle arrives two flops later
    assign byte_evt = st.byte_sync[1] ^ st.byte_seen;
    assign start_evt = st.start_sync[1] ^ st.start_seen;
    // SCL high may be shorter than a core cycle, so only its low level is
    // trusted; arming one cycle after the byte keeps flags settled.
    assign ninth_fall = st.ninth_armed && !st.scl_sync[1];

    always_comb begin
        next_st = st;
        next_st.rd_data = 8'h00;
        next_st.byte_sync = {st.byte_sync[0], ev.byte_tgl};
        next_st.start_sync = {st.start_sync[0], ev.start_tgl};
        next_st.scl_sync = {st.scl_sync[0], scl_clk_in};
        next_st.scl_last = st.scl_sync[1];
        next_st.byte_seen = st.byte_sync[1];
        next_st.start_seen = st.start_sync[1];
        if (start_evt) begin
            next_st.phase = ics_pkg::ICS_ADDR1;
            next_st.ninth_armed = 1'b0;
        end
        if (byte_evt) begin
            next_st.ninth_armed = 1'b1;
            unique case (st.phase)
                ics_pkg::ICS_IDLE: begin
                end
                ics_pkg::ICS_ADDR1: begin
                    if (st.ten_bit &&
                        ev.byte_val[7:3] == ics_pkg::TEN_BIT_MARK) begin
                        if (ev.byte_val[0] && st.matched_hi) begin
                            next_st.transmit = 1'b1;
                            next_st.phase = ics_pkg::ICS_DATA;
                        end else begin
                            next_st.address_update_flag = 1'b1;
                            next_st.addr_hold = 1'b1;
                            next_st.matched_hi = 1'b1;
                            next_st.phase = ics_pkg::ICS_ADDR2;
                        end
                    end else if (!st.ten_bit && ev.byte_val[7:1] ==
                                 st.slave_address_register[7:1]) begin
                        next_st.transmit = ev.byte_val[0];
                        next_st.phase = ics_pkg::ICS_DATA;
                    end else begin
                        next_st.phase = ics_pkg::ICS_IDLE;
                    end
                end
                ics_pkg::ICS_ADDR2: begin
                    next_st.address_update_flag = 1'b1;
                    next_st.addr_hold = 1'b1;
                    next_st.transmit = 1'b0;
                    next_st.phase = ics_pkg::ICS_DATA;
                end
                ics_pkg::ICS_DATA: begin
                    if (!st.transmit) begin
                        next_st.shift_data_buffer = ev.byte_val;
                        next_st.buffer_full_flag = 1'b1;
                    end else begin
                        next_st.buffer_full_flag = 1'b0;
                    end
                end
            endcase
        end
        if (ninth_fall) begin
            next_st.ninth_armed = 1'b0;
            // Only the data phase looks at the buffer flag; a matched address byte without address hold has already entered it
            if (st.phase == ics_pkg::ICS_DATA && !st.addr_hold) begin
                if (st.transmit && !st.buffer_full_flag) begin
                    next_st.clock_release_bit = 1'b0;
                end
                if (!st.transmit && st.stretch_enable &&
                    st.buffer_full_flag) begin
                    next_st.clock_release_bit = 1'b0;
                end
            end
        end
        if (wr_in) begin
            unique case (addr_in)
                ics_pkg::ADDR_CTRL: begin
                    next_st.stretch_enable = wdata_in[ics_pkg::CTRL_STRETCH];
                    next_st.ten_bit = wdata_in[ics_pkg::CTRL_TEN_BIT];
                    if (wdata_in[ics_pkg::CTRL_RELEASE]) begin
                        next_st.clock_release_bit = 1'b1;
                    end
                end
                ics_pkg::ADDR_DATA: begin
                    next_st.shift_data_buffer = wdata_in;
                    next_st.buffer_full_flag = 1'b1;
                end
                ics_pkg::ADDR_SLAVE: begin
                    next_st.slave_address_register = wdata_in;
                    next_st.address_update_flag = 1'b0;
                    next_st.addr_hold = 1'b0;
                end
                default: begin
                end
            endcase
        end
        if (rd_in) begin
            unique case (addr_in)
                ics_pkg::ADDR_CTRL: begin
                    next_st.rd_data[ics_pkg::CTRL_STRETCH] = st.stretch_enable;
                    next_st.rd_data[ics_pkg::CTRL_RELEASE] =
                        st.clock_release_bit;
                    next_st.rd_data[ics_pkg::CTRL_TEN_BIT] = st.ten_bit;
                end
                ics_pkg::ADDR_DATA: begin
                    next_st.rd_data = st.shift_data_buffer;
                    if (!st.transmit && !(byte_evt &&
                        st.phase == ics_pkg::ICS_DATA)) begin
                        next_st.buffer_full_flag = 1'b0;
                    end
                end
                ics_pkg::ADDR_SLAVE: begin
                    next_st.rd_data = st.slave_address_register;
                end
                ics_pkg::ADDR_STATUS: begin
                    next_st.rd_data[ics_pkg::ST_BUFFER_FULL] =
                        st.buffer_full_flag;
                    next_st.rd_data[ics_pkg::ST_ADDR_UPDATE] =
                        st.address_update_flag;
                    next_st.rd_data[ics_pkg::ST_TRANSMIT] = st.transmit;
                    next_st.rd_data[ics_pkg::ST_SCL_HELD] = scl_oe_out;
                    next_st.rd_data[ics_pkg::ST_RELEASE] =
                        st.clock_release_bit;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.clock_release_bit <= 1'b1;
            st.phase <= ics_pkg::ICS_IDLE;
            st.slave_address_register <= ics_pkg::SLAVE_RESET;
            st.shift_data_buffer <= ics_pkg::DATA_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Open-drain SCL: only ever pulled low; master must wait
    assign scl_oe_out = !st.clock_release_bit || st.addr_hold;
    assign scl_out = 1'b0;
    assign rdata_out = st.rd_data;

    a_release_holds_scl: assert property (@(posedge clk_in) disable iff (!rst_n)
        !st.clock_release_bit |-> scl_oe_out)
        else $error("SCL not held while release bit is low");
    a_sw_release: assert property (@(posedge clk_in) disable iff (!rst_n)
        wr_in && addr_in == ics_pkg::ADDR_CTRL &&
        wdata_in[ics_pkg::CTRL_RELEASE] |=> st.clock_release_bit)
        else $error("Release write not taken");
    a_addr_write_frees: assert property (@(posedge clk_in) disable iff (!rst_n)
        wr_in && addr_in == ics_pkg::ADDR_SLAVE |=> !st.addr_hold)
        else $error("Address hold not freed by address write");
    a_rx_no_sen: assert property (@(posedge clk_in) disable iff (!rst_n)
        ninth_fall && !st.transmit && !st.stretch_enable &&
        st.clock_release_bit && !(wr_in) |=> st.clock_release_bit)
        else $error("Receive stretch without stretch enable");
    a_rx_stretch: assert property (@(posedge clk_in) disable iff (!rst_n)
        ninth_fall && st.phase == ics_pkg::ICS_DATA && !st.addr_hold &&
        !st.transmit && st.stretch_enable && st.buffer_full_flag &&
        !wr_in |=> !st.clock_release_bit ##0 scl_oe_out)
        else $error("Receive stretch missed");
    a_tx_stretch: assert property (@(posedge clk_in) disable iff (!rst_n)
        ninth_fall && st.phase == ics_pkg::ICS_DATA && !st.addr_hold &&
        st.transmit && !st.buffer_full_flag &&
        !wr_in |=> !st.clock_release_bit)
        else $error("Transmit stretch missed");
    a_tx_loaded: assert property (@(posedge clk_in) disable iff (!rst_n)
        ninth_fall && st.transmit && st.buffer_full_flag &&
        st.clock_release_bit |=> st.clock_release_bit)
        else $error("Stretch with loaded buffer");
    a_addr_no_clear: assert property (@(posedge clk_in) disable iff (!rst_n)
        ninth_fall && st.phase != ics_pkg::ICS_DATA &&
        st.clock_release_bit |=> st.clock_release_bit)
        else $error("Release cleared in address byte");
    a_ua_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
        st.address_update_flag |-> scl_oe_out)
        else $error("Address update without stretch");
    a_addr_hold_scl: assert property (@(posedge clk_in) disable iff (!rst_n)
        st.addr_hold |-> scl_oe_out)
        else $error("Address hold without SCL low");
    a_tx_auto: assert property (@(posedge clk_in) disable iff (!rst_n)
        ninth_fall && st.phase == ics_pkg::ICS_DATA && !st.addr_hold &&
        st.transmit && !st.buffer_full_flag && !st.stretch_enable &&
        !wr_in |=> !st.clock_release_bit)
        else $error("Transmit stretch needs no enable");
    a_read_clears: assert property (@(posedge clk_in) disable iff (!rst_n)
        rd_in && addr_in == ics_pkg::ADDR_DATA && !st.transmit &&
        !byte_evt && !wr_in |=> !st.buffer_full_flag)
        else $error("Buffer read did not clear full flag");
    a_upper_sets_ua: assert property (@(posedge clk_in) disable iff (!rst_n)
        byte_evt && st.phase == ics_pkg::ICS_ADDR1 && st.ten_bit &&
        ev.byte_val[7:3] == ics_pkg::TEN_BIT_MARK && !ev.byte_val[0] &&
        !wr_in |=> st.address_update_flag)
        else $error("Upper address byte did not set update flag");
    a_tx_no_ua: assert property (@(posedge clk_in) disable iff (!rst_n)
        byte_evt && st.phase == ics_pkg::ICS_ADDR1 && st.ten_bit &&
        ev.byte_val[7:3] == ics_pkg::TEN_BIT_MARK && ev.byte_val[0] &&
        st.matched_hi && !st.address_update_flag |=>
        !st.address_update_flag && st.transmit)
        else $error("Read address set update flag");
    a_hold_no_clear: assert property (@(posedge clk_in) disable iff (!rst_n)
        ninth_fall && st.addr_hold && st.clock_release_bit |=>
        st.clock_release_bit)
        else $error("Release cleared during address hold");

    c_rx_stretch: cover property (@(posedge clk_in) disable iff (!rst_n)
        ninth_fall && !st.transmit ##1 !st.clock_release_bit);
    c_tx_stretch: cover property (@(posedge clk_in) disable iff (!rst_n)
        ninth_fall && st.transmit ##1 !st.clock_release_bit);
    c_ten_bit: cover property (@(posedge clk_in) disable iff (!rst_n)
        $rose(st.address_update_flag));
    c_ten_tx: cover property (@(posedge clk_in) disable iff (!rst_n)
        byte_evt && st.phase == ics_pkg::ICS_ADDR1 && st.matched_hi &&
        ev.byte_val[0]);
    c_sw_release: cover property (@(posedge clk_in) disable iff (!rst_n)
        !st.clock_release_bit ##1 st.clock_release_bit);
endmodule : ics_stretch
`default_nettype wire

// ==== verif/ics_master.sv ====
// I2C bus master model driving SCL and SDA toward the slave
`timescale 1ns/10ps
`default_nettype none
module ics_master (
    input wire logic scl_hold_in,
    output logic scl_out,
    output logic sda_out
);
    localparam int HALF = 80;
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // One SCL pulse; no rise while the slave holds SCL low
    task automatic pulse(input logic bit_val);
        sda_out = bit_val;
        #HALF;
        wait (!scl_hold_in);
        scl_out = 1'b1;
        #HALF;
        scl_out = 1'b0;
    endtask : pulse
    // Start: SDA falls while SCL is high, then SCL goes low
    task automatic start_frame();
        #37;
        sda_out = 1'b1;
        #HALF;
        wait (!scl_hold_in);
        scl_out = 1'b1;
        #HALF;
        sda_out = 1'b0;
        #HALF;
        scl_out = 1'b0;
    endtask : start_frame
    // Eight bits first to last, then the ack slot
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i]);
        end
        // No slave SDA driver here, so the pull-up wins the ack slot
        pulse(1'b1);
    endtask : send_byte
endmodule : ics_master
`default_nettype wire

// ==== verif/ics_stretch_tb.sv ====
// Testbench for the I2C slave clock stretching block
`timescale 1ns/10ps
`default_nettype none
module ics_stretch_tb;
    logic clk_in, rstn_in, wr_in, rd_in, m_scl, m_sda, scl_oe, scl_o;
    logic [2:0] addr_in;
    logic [7:0] wdata_in, rdata, st, d;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    // Open drain SCL: low if either party pulls it
    wire logic scl_line = m_scl & ~scl_oe;
    ics_stretch ics_stretch_i (.clk_in(clk_in), .rstn_in(rstn_in),
        .scl_clk_in(scl_line), .sda_in(m_sda), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata), .scl_oe_out(scl_oe), .scl_out(scl_o));
    ics_master ics_master_i (.scl_hold_in(scl_oe), .scl_out(m_scl),
        .sda_out(m_sda));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        v = rdata;
    endtask : rd
    // Give the stretch logic time to see the ninth fall, then look
    task automatic hold_is(input logic oe, input logic rel);
        repeat (8) @(posedge clk_in);
        @(negedge clk_in);
        check("scl_oe", {7'h00, scl_oe}, {7'h00, oe});
        rd(ics_pkg::ADDR_STATUS, st);
        check("release", {7'h00, st[ics_pkg::ST_RELEASE]}, {7'h00, rel});
    endtask : hold_is
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic t_reset();
        rd(ics_pkg::ADDR_STATUS, d);
        check("status", d, 8'h10);
        rd(ics_pkg::ADDR_SLAVE, d);
        check("slave", d, ics_pkg::SLAVE_RESET);
        rd(3'h5, d);
        check("unmapped", d, 8'h00);
        check("scl_out", {7'h00, scl_o}, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_rx7();
        wr(ics_pkg::ADDR_CTRL, 8'h01);
        wr(ics_pkg::ADDR_SLAVE, 8'h50);
        ics_master_i.start_frame();
        ics_master_i.send_byte(8'h50);
        rd(ics_pkg::ADDR_DATA, d);
        ics_master_i.send_byte(8'hA5);
        hold_is(1'b1, 1'b0);
        rd(ics_pkg::ADDR_DATA, d);
        check("rx data", d, 8'hA5);
        hold_is(1'b1, 1'b0);
        wr(ics_pkg::ADDR_CTRL, 8'h02);
        hold_is(1'b0, 1'b1);
        ics_master_i.send_byte(8'h3C);
        hold_is(1'b0, 1'b1);
        rd(ics_pkg::ADDR_DATA, d);
        check("rx data", d, 8'h3C);
        $display("test receive 7-bit done");
    endtask : t_rx7
    task automatic t_tx7();
        ics_master_i.start_frame();
        ics_master_i.send_byte(8'h51);
        hold_is(1'b1, 1'b0);
        check("transmit", {7'h00, st[ics_pkg::ST_TRANSMIT]}, 8'h01);
        wr(ics_pkg::ADDR_DATA, 8'h96);
        wr(ics_pkg::ADDR_CTRL, 8'h02);
        hold_is(1'b0, 1'b1);
        ics_master_i.send_byte(8'hFF);
        hold_is(1'b1, 1'b0);
        wr(ics_pkg::ADDR_CTRL, 8'h02);
        $display("test transmit 7-bit done");
    endtask : t_tx7
    task automatic t_ten();
        wr(ics_pkg::ADDR_CTRL, 8'h05);
        wr(ics_pkg::ADDR_SLAVE, 8'hF0);
        ics_master_i.start_frame();
        ics_master_i.send_byte(8'hF0);
        hold_is(1'b1, 1'b1);
        check("update", {7'h00, st[ics_pkg::ST_ADDR_UPDATE]}, 8'h01);
        wr(ics_pkg::ADDR_SLAVE, 8'h34);
        hold_is(1'b0, 1'b1);
        ics_master_i.send_byte(8'h34);
        hold_is(1'b1, 1'b1);
        wr(ics_pkg::ADDR_SLAVE, 8'hF0);
        rd(ics_pkg::ADDR_DATA, d);
        ics_master_i.send_byte(8'h5A);
        hold_is(1'b1, 1'b0);
        rd(ics_pkg::ADDR_DATA, d);
        check("rx data", d, 8'h5A);
        wr(ics_pkg::ADDR_CTRL, 8'h07);
        // Repeated upper byte with read turns the slave to transmit
        ics_master_i.start_frame();
        ics_master_i.send_byte(8'hF1);
        hold_is(1'b1, 1'b0);
        check("update", {7'h00, st[ics_pkg::ST_ADDR_UPDATE]}, 8'h00);
        wr(ics_pkg::ADDR_CTRL, 8'h06);
        $display("test 10-bit done");
    endtask : t_ten
    // A hang is cut short well past the expected run length
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        rstn_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 3'h0;
        wdata_in = 8'h00;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_reset();
        t_rx7();
        t_tx7();
        t_ten();
        report_and_stop();
    end
endmodule : ics_stretch_tb
`default_nettype wire
